// *** inc/pmes_pkg.sv ***
// Constants and types shared by the power-management event/status block
`default_nettype none
package pmes_pkg;
    // I/O map
    localparam logic [15:0] PMES_SCRATCH_ADDR  = 16'h00B3;
    localparam logic [6:0]  PMES_OFS_STS       = 7'h00;
    localparam logic [6:0]  PMES_OFS_EN        = 7'h02;
    localparam logic [6:0]  PMES_OFS_CTL       = 7'h04;
    localparam logic [6:0]  PMES_OFS_TMR       = 7'h08;
    localparam logic [6:0]  PMES_OFS_PCTL      = 7'h10;
    localparam logic [6:0]  PMES_OFS_LVL2      = 7'h14;
    localparam logic [6:0]  PMES_OFS_GP_EVENT0_STATUS  = 7'h28;
    localparam logic [6:0]  PMES_OFS_GP_EVENT0_ENABLE   = 7'h2A;
    localparam logic [6:0]  PMES_OFS_GP_EVENT1_STATUS  = 7'h2C;
    localparam logic [6:0]  PMES_OFS_GP_EVENT1_ENABLE   = 7'h2E;
    localparam logic [6:0]  PMES_OFS_SMI_CTL   = 7'h30;
    localparam logic [6:0]  PMES_OFS_SMI_STS   = 7'h34;
    localparam logic [6:0]  PMES_OFS_IOMON     = 7'h40;
    localparam logic [6:0]  PMES_OFS_DEVACT    = 7'h44;
    localparam logic [6:0]  PMES_OFS_BUSADR    = 7'h4C;
    localparam logic [6:0]  PMES_OFS_BUSCYC    = 7'h4E;
    localparam int          PMES_BASE_LSB      = 7;
    // Event status / enable bit positions
    localparam int PMES_B_TMROF   = 0;
    localparam int PMES_B_GLOBAL  = 5;
    localparam int PMES_B_POWER_BUTTON_N  = 8;
    localparam int PMES_B_RTC     = 10;
    localparam int PMES_B_OVRD    = 11;
    localparam int PMES_B_WAKE    = 15;
    // Control dword bits
    localparam int PMES_C_SCI_SEL = 0;
    localparam int PMES_C_FW_REL  = 1;
    localparam int PMES_C_SLEEP_ENTER  = 13;
    // Implemented-bit masks
    localparam logic [15:0] PMES_STS_MASK  = 16'h8D21;
    localparam logic [15:0] PMES_EN_MASK   = 16'h0521;
    localparam logic [31:0] PMES_CTL_MASK  = 32'h0000_2001;
    localparam logic [15:0] PMES_RST16     = 16'h0000;
    localparam logic [31:0] PMES_RST32     = 32'h0000_0000;
    localparam logic [7:0]  PMES_RST8      = 8'h00;
    localparam int          PMES_TMR_W     = 24;
    localparam int          PMES_TMR_OVF   = 22;
    // Timer ticks at 3.579545 MHz approximated by a 13-cycle divider at 50 MHz
    localparam int          PMES_CLK_HZ    = 50_000_000;
    localparam int          PMES_TICK_HZ   = 3_579_545;
    localparam int          PMES_TICK_DIV  = PMES_CLK_HZ / PMES_TICK_HZ;
    localparam int          PMES_OVRD_S    = 4;
    localparam longint      PMES_OVRD_CYC  = longint'(PMES_OVRD_S) * PMES_CLK_HZ;
    // System power state, one-hot
    typedef enum logic [1:0] {
        PMES_S0    = 2'b01,
        PMES_SLEEP = 2'b10
    } pmes_state_e;
endpackage : pmes_pkg
`default_nettype wire

// *** hdl/pmes_top.sv ***
// Power-management I/O register block with event status, wake and interrupt routing
`default_nettype none
module pmes_top
    import pmes_pkg::*;
#(
    parameter longint OVRD_CYCLES = PMES_OVRD_CYC
)(
    // Clock and resets
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    input  wire logic        i_resume_well_reset_n,
    input  wire logic        i_rtc_well_reset_n,
    input  wire logic        i_pci_reset_n,
    // Decode configuration
    input  wire logic        i_pm_block_decode_enable,
    input  wire logic [8:0]  i_pm_block_base,
    // I/O access
    input  wire logic [15:0] i_io_addr,
    input  wire logic        i_io_rd,
    input  wire logic        i_io_wr,
    input  wire logic [3:0]  i_io_be,
    input  wire logic [31:0] i_io_wdata,
    output logic [31:0]      o_io_rdata,
    output logic             o_io_hit,
    // Event pins
    input  wire logic        i_power_button_n,
    input  wire logic        i_rtc_alarm_irq_n,
    // Event outputs
    output logic             o_sci,
    output logic             o_system_mgmt_irq_n,
    output logic             o_wake,
    output logic             o_sleep_state,
    output logic             o_force_s5,
    output logic             o_after_power_loss_flag
);
    import pmes_pkg::*;

    typedef struct packed {
        logic [2:0]  btn_sync;
        logic [2:0]  rtc_sync;
        logic        btn_lvl;
        logic        rtc_lvl;
        logic [7:0]  sts_core;
        logic [15:0] en;
        logic [31:0] ctl;
        logic [PMES_TMR_W-1:0] tmr;
        logic [3:0]  tick_cnt;
        logic [31:0] pctl;
        logic [15:0] gp_event0_status;
        logic [15:0] gp_event0_enable;
        logic [15:0] gp_event1_status;
        logic [15:0] gp_event1_enable;
        logic [15:0] smi_ctl;
        logic [15:0] smi_sts;
        logic [15:0] iomon;
        logic [15:0] devact;
        logic [15:0] bus_adr;
        logic [7:0]  bus_cyc;
        logic [31:0] rdata;
        logic        hit;
        logic        sci;
        logic        smi_n;
    } pmes_core_s;

    pmes_core_s  core_ff, nxt_core;
    // Resume-well and RTC-well bits sit on their own resets
    logic        wake_sts_ff, nxt_wake_sts;
    logic        rtc_alarm_status_ff, nxt_rtc_alarm_status;
    logic        btn_sts_ff, nxt_btn_sts;
    logic        ovrd_sts_ff, nxt_ovrd_sts;
    logic        apl_ff, nxt_apl;
    logic        wake_ff, nxt_wake;
    logic        s5_ff, nxt_s5;
    logic [31:0] press_ff, nxt_press;
    pmes_state_e state_ff, nxt_state;
    logic [7:0]  scratch_ff, nxt_scratch;

    function automatic logic [15:0] wmask16(input logic [1:0] be);
        wmask16 = {{8{be[1]}}, {8{be[0]}}};
    endfunction : wmask16

    // Byte-lane word-write helper for 16-bit registers in either half of a dword
    function automatic logic [15:0] upd16(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] be, input logic [15:0] msk);
        logic [15:0] m;
        m = wmask16(be) & msk;
        upd16 = (old & ~m) | (d & m);
    endfunction : upd16

    logic        blk_hit;
    logic [6:0]  ofs;
    logic [6:0]  dw;
    logic [31:0] wd;
    logic        wr_blk;
    logic        rd_blk;
    logic        sc_hit;
    logic [15:0] sts_rd;
    logic [15:0] w1c;
    logic        btn_low;
    logic        rtc_edge;
    logic        long_press;
    logic        ev_sci;
    logic        ev_smi;
    logic        ev_wake;

    always_comb
    begin
        blk_hit = i_pm_block_decode_enable
                  && (i_io_addr[15:PMES_BASE_LSB] == i_pm_block_base);
        ofs     = i_io_addr[6:0];
        dw      = {ofs[6:2], 2'b00};
        wd      = i_io_wdata;
        wr_blk  = blk_hit && i_io_wr;
        rd_blk  = blk_hit && i_io_rd;
        sc_hit  = (i_io_addr == PMES_SCRATCH_ADDR);
        btn_low = (core_ff.btn_sync[1] == core_ff.btn_sync[2]) ? ~core_ff.btn_sync[2] : core_ff.btn_lvl;
        long_press = btn_low && (press_ff >= 32'(OVRD_CYCLES - 1));
        rtc_edge = ~core_ff.rtc_lvl && (core_ff.rtc_sync[1] == core_ff.rtc_sync[2])
                   && ~core_ff.rtc_sync[2];
        sts_rd = 16'h0000;
        sts_rd[7:0]          = core_ff.sts_core;
        sts_rd[PMES_B_POWER_BUTTON_N] = btn_sts_ff;
        sts_rd[PMES_B_RTC]    = rtc_alarm_status_ff;
        sts_rd[PMES_B_OVRD]   = ovrd_sts_ff;
        sts_rd[PMES_B_WAKE]   = wake_sts_ff;
        w1c = (wr_blk && dw == PMES_OFS_STS) ? (wd[15:0] & wmask16(i_io_be[1:0]) & PMES_STS_MASK)
                                             : 16'h0000;
        // Global bit feeds SCI only; timer bit never wakes
        ev_sci  = (core_ff.sts_core[PMES_B_GLOBAL] && core_ff.en[PMES_B_GLOBAL]);
        ev_smi  = (core_ff.sts_core[PMES_B_TMROF] && core_ff.en[PMES_B_TMROF])
                  || (btn_sts_ff && core_ff.en[PMES_B_POWER_BUTTON_N])
                  || (rtc_alarm_status_ff && core_ff.en[PMES_B_RTC]);
        ev_wake = (btn_sts_ff && (core_ff.en[PMES_B_POWER_BUTTON_N] || s5_ff))
                  || (rtc_alarm_status_ff && core_ff.en[PMES_B_RTC]);
    end

    always_comb
    begin
        nxt_core = core_ff;
        nxt_core.btn_sync = {core_ff.btn_sync[1:0], i_power_button_n};
        nxt_core.rtc_sync = {core_ff.rtc_sync[1:0], i_rtc_alarm_irq_n};
        if (core_ff.btn_sync[1] == core_ff.btn_sync[2])
        begin
            nxt_core.btn_lvl = ~core_ff.btn_sync[2];
        end
        if (core_ff.rtc_sync[1] == core_ff.rtc_sync[2])
        begin
            nxt_core.rtc_lvl = ~core_ff.rtc_sync[2];
        end
        // Power-management timer, ticking from a divider enable
        if (core_ff.tick_cnt == 4'(PMES_TICK_DIV - 1))
        begin
            nxt_core.tick_cnt = 4'h0;
            nxt_core.tmr      = core_ff.tmr + 1'b1;
        end
        else
        begin
            nxt_core.tick_cnt = core_ff.tick_cnt + 1'b1;
        end
        // Core status bits: write-one clear, hardware set wins
        nxt_core.sts_core = core_ff.sts_core & ~w1c[7:0];
        if (nxt_core.tmr[PMES_TMR_OVF] && !core_ff.tmr[PMES_TMR_OVF])
        begin
            nxt_core.sts_core[PMES_B_TMROF] = 1'b1;
        end
        if (wr_blk && dw == PMES_OFS_CTL && i_io_be[0] && wd[PMES_C_FW_REL])
        begin
            nxt_core.sts_core[PMES_B_GLOBAL] = 1'b1;
        end
        if (wr_blk)
        begin
            unique case (dw)
                PMES_OFS_STS:
                    nxt_core.en = upd16(core_ff.en, wd[31:16], i_io_be[3:2], PMES_EN_MASK);
                PMES_OFS_CTL:
                begin
                    nxt_core.ctl[15:0] = upd16(core_ff.ctl[15:0], wd[15:0], i_io_be[1:0],
                                               PMES_CTL_MASK[15:0] & ~(16'h0001 << PMES_C_SLEEP_ENTER));
                end
                PMES_OFS_PCTL:
                    nxt_core.pctl = (core_ff.pctl & ~{wmask16(i_io_be[3:2]), wmask16(i_io_be[1:0])})
                                    | (wd & {wmask16(i_io_be[3:2]), wmask16(i_io_be[1:0])});
                PMES_OFS_GP_EVENT0_STATUS:
                begin
                    nxt_core.gp_event0_status = upd16(core_ff.gp_event0_status, wd[15:0], i_io_be[1:0], 16'hFFFF);
                    nxt_core.gp_event0_enable  = upd16(core_ff.gp_event0_enable, wd[31:16], i_io_be[3:2], 16'hFFFF);
                end
                PMES_OFS_GP_EVENT1_STATUS:
                begin
                    nxt_core.gp_event1_status = upd16(core_ff.gp_event1_status, wd[15:0], i_io_be[1:0], 16'hFFFF);
                    nxt_core.gp_event1_enable  = upd16(core_ff.gp_event1_enable, wd[31:16], i_io_be[3:2], 16'hFFFF);
                end
                PMES_OFS_SMI_CTL:
                    nxt_core.smi_ctl = upd16(core_ff.smi_ctl, wd[15:0], i_io_be[1:0], 16'hFFFF);
                PMES_OFS_SMI_STS:
                    nxt_core.smi_sts = upd16(core_ff.smi_sts, wd[15:0], i_io_be[1:0], 16'hFFFF);
                PMES_OFS_IOMON:
                    nxt_core.iomon = upd16(core_ff.iomon, wd[15:0], i_io_be[1:0], 16'hFFFF);
                PMES_OFS_DEVACT:
                    nxt_core.devact = upd16(core_ff.devact, wd[15:0], i_io_be[1:0], 16'hFFFF);
                default:
                    nxt_core.hit = core_ff.hit;
            endcase
        end
        // Long press leaves only the button as a wake source
        if (long_press)
        begin
            nxt_core.en = 16'h0000;
        end
        if (blk_hit && (i_io_rd || i_io_wr))
        begin
            nxt_core.bus_adr = i_io_addr;
            nxt_core.bus_cyc = {6'h00, i_io_wr, i_io_rd};
        end
        nxt_core.hit   = rd_blk || (sc_hit && i_io_rd);
        nxt_core.rdata = 32'h0000_0000;
        if (sc_hit && i_io_rd)
        begin
            nxt_core.rdata = {24'h00_0000, scratch_ff};
        end
        else if (rd_blk)
        begin
            unique case (dw)
                PMES_OFS_STS:      nxt_core.rdata = {core_ff.en, sts_rd};
                PMES_OFS_CTL:      nxt_core.rdata = core_ff.ctl;
                PMES_OFS_TMR:      nxt_core.rdata = {8'h00, core_ff.tmr};
                PMES_OFS_PCTL:     nxt_core.rdata = core_ff.pctl;
                PMES_OFS_LVL2:     nxt_core.rdata = 32'h0000_0000;
                PMES_OFS_GP_EVENT0_STATUS: nxt_core.rdata = {core_ff.gp_event0_enable, core_ff.gp_event0_status};
                PMES_OFS_GP_EVENT1_STATUS: nxt_core.rdata = {core_ff.gp_event1_enable, core_ff.gp_event1_status};
                PMES_OFS_SMI_CTL:  nxt_core.rdata = {16'h0000, core_ff.smi_ctl};
                PMES_OFS_SMI_STS:  nxt_core.rdata = {16'h0000, core_ff.smi_sts};
                PMES_OFS_IOMON:    nxt_core.rdata = {16'h0000, core_ff.iomon};
                PMES_OFS_DEVACT:   nxt_core.rdata = {16'h0000, core_ff.devact};
                PMES_OFS_BUSADR:   nxt_core.rdata = {8'h00, core_ff.bus_cyc, core_ff.bus_adr};
                default:           nxt_core.rdata = 32'h0000_0000;
            endcase
        end
        // Interrupt routing only while working
        nxt_core.sci   = (state_ff == PMES_S0) && ((ev_smi && core_ff.ctl[PMES_C_SCI_SEL]) || ev_sci);
        nxt_core.smi_n = !((state_ff == PMES_S0) && ev_smi && !core_ff.ctl[PMES_C_SCI_SEL]);
    end

    // Resume/RTC-well bits and system state
    always_comb
    begin
        nxt_wake_sts = wake_sts_ff & ~w1c[PMES_B_WAKE];
        nxt_rtc_alarm_status  = rtc_alarm_status_ff & ~w1c[PMES_B_RTC];
        nxt_btn_sts  = btn_sts_ff & ~w1c[PMES_B_POWER_BUTTON_N];
        nxt_ovrd_sts = ovrd_sts_ff & ~w1c[PMES_B_OVRD];
        nxt_apl      = apl_ff;
        nxt_state    = state_ff;
        nxt_s5       = s5_ff;
        nxt_wake     = 1'b0;
        nxt_press    = btn_low ? press_ff + 1'b1 : 32'h0000_0000;
        if (rtc_edge)
        begin
            nxt_rtc_alarm_status = 1'b1;
        end
        if (btn_low && !core_ff.btn_lvl)
        begin
            nxt_btn_sts = 1'b1;
        end
        if (wr_blk && dw == PMES_OFS_CTL && i_io_be[1] && wd[PMES_C_SLEEP_ENTER])
        begin
            nxt_state = PMES_SLEEP;
        end
        else if (state_ff == PMES_SLEEP && ev_wake)
        begin
            nxt_wake_sts = 1'b1;
            nxt_wake     = 1'b1;
            nxt_state    = PMES_S0;
            nxt_s5       = 1'b0;
        end
        if (long_press)
        begin
            nxt_btn_sts  = 1'b0;
            nxt_ovrd_sts = 1'b1;
            nxt_apl      = 1'b1;
            nxt_state    = PMES_SLEEP;
            nxt_s5       = 1'b1;
            nxt_press    = 32'h0000_0000;
        end
    end

    // Core well: lost on hard resets including the hard reset port
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            core_ff       <= '0;
            core_ff.smi_n <= 1'b1;
            core_ff.btn_sync <= 3'b111;
            core_ff.rtc_sync <= 3'b111;
            state_ff      <= PMES_S0;
            wake_ff       <= 1'b0;
            press_ff      <= 32'h0000_0000;
        end
        else
        begin
            core_ff  <= nxt_core;
            state_ff <= nxt_state;
            wake_ff  <= nxt_wake;
            press_ff <= nxt_press;
        end
    end

    // Resume well: only the resume-well reset clears these
    always_ff @(posedge i_clock or negedge i_resume_well_reset_n)
    begin
        if (!i_resume_well_reset_n)
        begin
            wake_sts_ff <= 1'b0;
            rtc_alarm_status_ff  <= 1'b0;
            btn_sts_ff  <= 1'b0;
            s5_ff       <= 1'b0;
        end
        else
        begin
            wake_sts_ff <= nxt_wake_sts;
            rtc_alarm_status_ff  <= nxt_rtc_alarm_status;
            btn_sts_ff  <= nxt_btn_sts;
            s5_ff       <= nxt_s5;
        end
    end

    // RTC well survives power failure
    always_ff @(posedge i_clock or negedge i_rtc_well_reset_n)
    begin
        if (!i_rtc_well_reset_n)
        begin
            ovrd_sts_ff <= 1'b0;
            apl_ff      <= 1'b0;
        end
        else
        begin
            ovrd_sts_ff <= nxt_ovrd_sts;
            apl_ff      <= nxt_apl;
        end
    end

    // Scratchpad: PCI reset only, no other function touches it
    always_comb
    begin
        nxt_scratch = scratch_ff;
        if (sc_hit && i_io_wr && i_io_be[0])
        begin
            nxt_scratch = i_io_wdata[7:0];
        end
    end

    always_ff @(posedge i_clock or negedge i_pci_reset_n)
    begin
        if (!i_pci_reset_n)
        begin
            scratch_ff <= PMES_RST8;
        end
        else
        begin
            scratch_ff <= nxt_scratch;
        end
    end

    assign o_io_rdata              = core_ff.rdata;
    assign o_io_hit                = core_ff.hit;
    assign o_sci                   = core_ff.sci;
    assign o_system_mgmt_irq_n     = core_ff.smi_n;
    assign o_wake                  = wake_ff;
    assign o_sleep_state           = state_ff[1];
    assign o_force_s5              = s5_ff;
    assign o_after_power_loss_flag = apl_ff;

    sleep_wake_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (state_ff == PMES_SLEEP && ev_wake && !long_press && !(wr_blk && dw == PMES_OFS_CTL))
        |=> (wake_sts_ff && wake_ff && state_ff == PMES_S0))
        else $error("wake not taken");
    wake_clear_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (wake_sts_ff && w1c[PMES_B_WAKE] && !(state_ff == PMES_SLEEP && ev_wake)) |=> !wake_sts_ff)
        else $error("wake status not cleared");
    btn_set_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (btn_low && !core_ff.btn_lvl && !long_press) |=> btn_sts_ff)
        else $error("button status not set");
    ovrd_set_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        long_press |=> (ovrd_sts_ff && apl_ff && !btn_sts_ff && s5_ff))
        else $error("override missed");
    rtc_set_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        rtc_edge |=> rtc_alarm_status_ff)
        else $error("rtc status not set");
    sci_route_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (state_ff == PMES_S0 && ev_smi && !core_ff.ctl[PMES_C_SCI_SEL]) |=> !o_system_mgmt_irq_n)
        else $error("smi not raised");
    tmr_ovf_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        $rose(core_ff.tmr[PMES_TMR_OVF]) |-> core_ff.sts_core[PMES_B_TMROF])
        else $error("timer status not set");
    decode_off_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (i_io_rd && !i_pm_block_decode_enable && !sc_hit) |=> !o_io_hit)
        else $error("decode while disabled");
    global_smi_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (!ev_smi) |=> o_system_mgmt_irq_n)
        else $error("global caused smi");

    wake_seen_c:  cover property (@(posedge i_clock) disable iff (!i_rstn) $rose(wake_ff));
    ovrd_seen_c:  cover property (@(posedge i_clock) disable iff (!i_rstn) long_press);
    sci_seen_c:   cover property (@(posedge i_clock) disable iff (!i_rstn) $rose(o_sci));
endmodule : pmes_top
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the power-management event/status block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pmes_pkg::*;
    localparam longint      OVRD = 20;
    localparam logic [15:0] B    = 16'h0880;
    // Pin selectors for the pulse task
    localparam int          P_PB = 0;
    localparam int          P_AL = 1;
    localparam int          P_RS = 2;
    localparam int          P_RW = 3;
    localparam int          P_PC = 4;
    logic        clk, rstn, rsm_n, rtc_n, pci_n, den, rd, wr, pb_n, alm_n;
    logic        sci, smi_n, wake, slp, s5, apl, hit, woke;
    logic [15:0] addr;
    logic [3:0]  be;
    logic [31:0] wd, rdata, d;
    int          failures, comparisons, cyc;
    pmes_top #(.OVRD_CYCLES(OVRD)) u_pmes_top (.i_clock(clk), .i_rstn(rstn), .i_resume_well_reset_n(rsm_n),
        .i_rtc_well_reset_n(rtc_n), .i_pci_reset_n(pci_n), .i_pm_block_decode_enable(den),
        .i_pm_block_base(9'h011), .i_io_addr(addr), .i_io_rd(rd), .i_io_wr(wr), .i_io_be(be),
        .i_io_wdata(wd), .o_io_rdata(rdata), .o_io_hit(hit), .i_power_button_n(pb_n),
        .i_rtc_alarm_irq_n(alm_n), .o_sci(sci), .o_system_mgmt_irq_n(smi_n), .o_wake(wake),
        .o_sleep_state(slp), .o_force_s5(s5), .o_after_power_loss_flag(apl));
    initial
    begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    // Wake is a one-cycle pulse, so it is latched here for later inspection
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (wake === 1'b1) woke <= 1'b1;
        if (cyc == 5000)
        begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic io(input logic w, input logic [15:0] a, input logic [3:0] b, input logic [31:0] v);
        @(posedge clk);
        {rd, wr, addr, be, wd} <= {!w, w, a, b, v};
        @(posedge clk);
        {rd, wr} <= 2'b00;
        #1 d = rdata;
    endtask : io
    // Drives the module-level pin itself; a copied-out argument would only land at task return
    task automatic drive_pin(input int sel, input logic v);
        case (sel)
            P_PB:    pb_n  <= v;
            P_AL:    alm_n <= v;
            P_RS:    rstn  <= v;
            P_RW:    rsm_n <= v;
            default: pci_n <= v;
        endcase
    endtask : drive_pin
    task automatic pulse_pin(input int sel, input int n);
        @(posedge clk);
        drive_pin(sel, 1'b0);
        repeat (n) @(posedge clk);
        drive_pin(sel, 1'b1);
        repeat (8) @(posedge clk);
    endtask : pulse_pin
    task automatic t_map;
        io(0, B + 16'h34, 4'hf, 0);
        check(d, 0);
        io(1, B + 16'h28, 4'hf, 32'hABCD_1234);
        io(0, B + 16'h28, 4'hf, 0);
        check(d, 32'hABCD_1234);
        io(1, B + 16'h0C, 4'hf, 32'hFFFF_FFFF);
        io(0, B + 16'h0C, 4'hf, 0);
        check(hit, 1);
        check(d, 0);
        io(1, B, 4'b1100, 32'hFFFF_0000);
        io(0, B, 4'hf, 0);
        check(d, 32'h0521_0000);
        io(1, B, 4'b1100, 0);
    endtask : t_map
    task automatic t_decode;
        den <= 1'b0;
        io(0, B, 4'hf, 0);
        check(hit, 0);
        check(d, 0);
        den <= 1'b1;
        io(1, 16'h00B3, 4'b0001, 32'h0000_005A);
        io(0, 16'h00B3, 4'b0001, 0);
        check(d[7:0], 8'h5A);
        pulse_pin(P_PC, 2);
        io(0, 16'h00B3, 4'b0001, 0);
        check(d[7:0], 8'h00);
    endtask : t_decode
    task automatic t_button;
        pulse_pin(P_PB, 6);
        io(0, B, 4'hf, 0);
        check({sci, smi_n, d[15:0] & 16'h0100}, {2'b01, 16'h0100});
        io(1, B + 16'h04, 4'b0011, 32'h1);
        io(1, B, 4'b1100, 32'h0100_0000);
        repeat (2) @(posedge clk);
        check(sci, 1);
        io(1, B + 16'h04, 4'b0011, 32'h0);
        repeat (2) @(posedge clk);
        check({sci, smi_n}, 2'b00);
        io(1, B, 4'b0011, 32'h0100);
        io(0, B, 4'hf, 0);
        check({smi_n, d[15:0] & 16'h0100}, {1'b1, 16'h0});
    endtask : t_button
    task automatic t_wake;
        io(1, B, 4'b1100, 32'h0400_0000);
        io(1, B + 16'h04, 4'b0011, 32'h2000);
        repeat (2) @(posedge clk);
        check(slp, 1);
        pulse_pin(P_AL, 3);
        io(0, B, 4'hf, 0);
        check({woke, slp, d[15:0] & 16'h8400}, {2'b10, 16'h8400});
        pulse_pin(P_RS, 2);
        io(0, B, 4'hf, 0);
        check(d[15:0] & 16'h8400, 16'h8400);
        io(1, B, 4'b0011, 32'h8000);
        io(0, B, 4'hf, 0);
        check(d[15:0] & 16'h8400, 16'h0400);
        pulse_pin(P_RW, 2);
        io(0, B, 4'hf, 0);
        check(d[15:0] & 16'h8500, 16'h0);
    endtask : t_wake
    task automatic t_long;
        pulse_pin(P_PB, int'(OVRD) + 12);
        io(0, B, 4'hf, 0);
        check({s5, apl, d[15:0] & 16'h0900}, {2'b11, 16'h0800});
        io(1, B, 4'b0011, 32'h0800);
        io(0, B, 4'hf, 0);
        check(d[15:0] & 16'h0800, 16'h0);
    endtask : t_long
    task automatic tally_and_finish;
        $display("Comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        {rstn, rsm_n, rtc_n, pci_n, den, rd, wr, woke} = 8'h0;
        {pb_n, alm_n, addr, be, wd, failures, comparisons, cyc} = {2'b11, 52'h0, 96'h0};
        repeat (6) @(posedge clk);
        {rstn, rsm_n, rtc_n, pci_n, den} <= 5'h1F;
        t_map();
        t_decode();
        t_button();
        t_wake();
        t_long();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
